/* rtl/dewg_data_eeprom_write_guard.sv */
// data eeprom with store guard: memory, registers, unlock check, interrupt
// the store itself is modelled as a cycle count ending in one array write
// assumes one clock, synchronous resets from the device reset logic and a
// cpu that drives the register port on the same clock
// assumes the protect strap is static; it is deliberately not consulted
//
// The strobed register port is this design's own decision.
`default_nettype none
`include "dewg_params.svh"

// Summary of operation
// - power-on reset clears the store permit latch.
// - no store may start while the power-up delay counter runs.
// - a store starts only after a good unlock with the permit latch set.
// - code protection changes nothing; contents stay plain and accessible.
// - control resets to 0000 on power-on, abort flag conditional elsewhere.
// - data and address clear on power-on, keep value on other resets.
// - unlock port stores nothing, only feeds the detector, reads as zero.
// - upper four control bits ignore writes and read as zero.
// - 55h then aah to unlock then store trigger, exact spacing, else skip.
// - triggers only settable; hardware clears them, fetch takes one cycle.
// - other reset during a store sets abort flag, data and address kept.
// - finished store clears trigger, sets done flag; firmware clears it.
module dewg_data_eeprom_write_guard
#(
	parameter int POWERUP_DELAY_TIMER_CYCLES  = `DEWG_POWERUP_DELAY_TIMER_CYCLES,
	parameter int STORE_CYCLES = `DEWG_STORE_CYCLES,
	parameter int SEQ_GAP      = `DEWG_SEQ_GAP
)
(
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       powerOnRst,
	input  wire logic       codeProtect,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWrEn,
	input  wire logic       regRdEn,
	output logic      [7:0] regRdData,
	output logic            irq
);

	// refuse settings the counters cannot hold
	initial
	begin
		if (POWERUP_DELAY_TIMER_CYCLES < 1 || POWERUP_DELAY_TIMER_CYCLES >= (1 << `DEWG_POWERUP_DELAY_TIMER_W))
			$error("POWERUP_DELAY_TIMER_CYCLES out of range");
		if (STORE_CYCLES < 1 || STORE_CYCLES >= (1 << `DEWG_STORE_W))
			$error("STORE_CYCLES out of range");
		if (SEQ_GAP < 1 || SEQ_GAP >= (1 << `DEWG_SEQ_W))
			$error("SEQ_GAP out of range");
		// the array index below is seven bits wide
		if (`DEWG_DEPTH != 128)
			$error("memory depth must be 128");
	end

	// counter loads; the store counter ends on zero, hence the minus one
	localparam logic [`DEWG_POWERUP_DELAY_TIMER_W-1:0]  POWERUP_DELAY_TIMER_LOAD =
		`DEWG_POWERUP_DELAY_TIMER_W'(POWERUP_DELAY_TIMER_CYCLES);
	localparam logic [`DEWG_STORE_W-1:0] STORE_LOAD =
		`DEWG_STORE_W'(STORE_CYCLES - 1);
	localparam logic [`DEWG_SEQ_W-1:0]   SEQ_LAST =
		`DEWG_SEQ_W'(SEQ_GAP - 1);

	// present state, its next value and the two reset images
	dewg_pkg::dewg_state_s s;
	dewg_pkg::dewg_state_s next_s;
	dewg_pkg::dewg_state_s porState;
	dewg_pkg::dewg_state_s rstState;

	// contents kept plain: no scrambling, protect strap is not consulted
	logic [7:0] mem [`DEWG_DEPTH];
	logic       memWe;
	logic [6:0] memIdx;

	// one-cycle decodes of a register write
	logic       wrData;
	logic       wrAddr;
	logic       wrCtrl;
	logic       wrUnlock;
	logic       wrClear;
	logic       wrEnable;

	// unlock spacing and store start qualifiers
	logic       stepOk;
	logic       startOk;

	// write-one-to-clear mask, one bit per interrupt source
	logic [`DEWG_IRQ_W-1:0] irqClr;

	// strap ends on a sink: protection must not alter the data path
	logic       unusedProtect;

	// sink only; plain contents whatever the strap says
	assign unusedProtect = codeProtect;
	// upper address bit is decoded away, only 128 bytes exist
	assign memIdx = s.addr[6:0];

	// write decode
	// unmapped offsets select nothing, so such writes are lost
	always_comb
	begin
		wrData   = 1'b0;
		wrAddr   = 1'b0;
		wrCtrl   = 1'b0;
		wrUnlock = 1'b0;
		wrClear  = 1'b0;
		wrEnable = 1'b0;
		if (!regWrEn)
			wrData = 1'b0;
		else if (regAddr == `DEWG_OFS_DATA)
			wrData = 1'b1;
		else if (regAddr == `DEWG_OFS_ADDRESS)
			wrAddr = 1'b1;
		else if (regAddr == `DEWG_OFS_CONTROL)
			wrCtrl = 1'b1;
		else if (regAddr == `DEWG_OFS_UNLOCK)
			wrUnlock = 1'b1;
		else if (regAddr == `DEWG_OFS_CLEAR)
			wrClear = 1'b1;
		else if (regAddr == `DEWG_OFS_ENABLE)
			wrEnable = 1'b1;
	end

	// per-bit clear mask; a write of zero leaves a flag alone
	generate
		for (genvar gi = 0; gi < `DEWG_IRQ_W; gi++)
		begin : g_irq_clr
			assign irqClr[gi] = wrClear && regWrData[gi];
		end
	endgenerate

	// a step of the sequence counts only at the exact spacing
	assign stepOk = (s.seqCnt == SEQ_LAST);

	// start needs unlock, permit latch, power-up delay over, no store busy
	// a refused start still lets the rest of that control write land
	assign startOk = wrCtrl && regWrData[`DEWG_BIT_STORE]
		&& s.seq == dewg_pkg::SEQ_ARMED && stepOk
		&& s.permit
		&& s.pwrtCnt == '0
		&& !s.store;

	// next state in normal running
	// everything holds by default; read data fall back to zero
	always_comb
	begin
		next_s = s;
		memWe = 1'b0;
		next_s.rdData = 8'h00;

		// power-up delay counts down once after power-on
		if (s.pwrtCnt != '0)
			next_s.pwrtCnt = s.pwrtCnt - 1'b1;

		// unlock detector: any other write or a late step drops it
		// a 55h at any time restarts, so a retry needs no wait
		if (s.seq != dewg_pkg::SEQ_IDLE)
			next_s.seqCnt = s.seqCnt + 1'b1;
		if (s.seq != dewg_pkg::SEQ_IDLE && (stepOk || regWrEn))
			next_s.seq = dewg_pkg::SEQ_IDLE;
		if (wrUnlock && regWrData == `DEWG_KEY_SECOND
			&& s.seq == dewg_pkg::SEQ_GOT_FIRST && stepOk)
		begin
			next_s.seq = dewg_pkg::SEQ_ARMED;
			next_s.seqCnt = '0;
		end
		else if (wrUnlock && regWrData == `DEWG_KEY_FIRST)
		begin
			next_s.seq = dewg_pkg::SEQ_GOT_FIRST;
			next_s.seqCnt = '0;
		end

		// plain register writes
		if (wrData)
			next_s.data = regWrData;
		if (wrAddr)
			next_s.addr = regWrData;
		if (wrEnable)
			next_s.enable = regWrData[`DEWG_IRQ_W-1:0];
		if (wrCtrl)
		begin
			// bits 7:4 have no storage at all
			next_s.abortFlag = regWrData[`DEWG_BIT_ABORT];
			next_s.permit = regWrData[`DEWG_BIT_PERMIT];
			// triggers can only be set, never cleared by a write
			// a fetch is dropped while a store runs
			if (regWrData[`DEWG_BIT_FETCH] && !s.store)
				next_s.fetch = 1'b1;
		end
		if (startOk)
		begin
			next_s.store = 1'b1;
			next_s.storeCnt = STORE_LOAD;
		end

		// one-cycle fetch into the data register
		// array read is combinational; the byte lands next edge
		if (s.fetch)
		begin
			next_s.data = mem[memIdx];
			next_s.fetch = 1'b0;
		end

		// store timing; clearing permit mid-store does not stop it
		// data and address are used at the end, not at the start
		if (s.store)
		begin
			next_s.storeCnt = s.storeCnt - 1'b1;
			if (s.storeCnt == '0)
			begin
				memWe = 1'b1;
				next_s.store = 1'b0;
			end
		end

		// clear first so a coinciding set survives
		next_s.status = s.status & ~irqClr;
		if (memWe)
			next_s.status[`DEWG_IRQ_DONE] = 1'b1;

		// read data stand in the following cycle only
		// unmapped and write-only offsets read as zero
		if (regRdEn)
		begin
			if (regAddr == `DEWG_OFS_DATA)
				next_s.rdData = s.data;
			else if (regAddr == `DEWG_OFS_ADDRESS)
				next_s.rdData = s.addr;
			else if (regAddr == `DEWG_OFS_CONTROL)
				next_s.rdData = {4'h0, s.abortFlag, s.permit,
					s.store, s.fetch};
			else if (regAddr == `DEWG_OFS_UNLOCK)
				next_s.rdData = 8'h00;
			else if (regAddr == `DEWG_OFS_STATUS)
				next_s.rdData = {6'h00, s.status};
			else if (regAddr == `DEWG_OFS_ENABLE)
				next_s.rdData = {6'h00, s.enable};
			else
				next_s.rdData = 8'h00;
		end

		// irq follows next status, rising with the flag
		next_s.irq = |(next_s.status & next_s.enable);
	end

	// power-on values: all control clear, delay timer loaded
	// data and address registers power on as zero; the array contents are not cleared
	always_comb
	begin
		porState = '0;
		porState.data = `DEWG_POR_BYTE;
		porState.addr = `DEWG_POR_BYTE;
		porState.abortFlag = 1'b0;
		porState.permit = 1'b0;
		porState.seq = dewg_pkg::SEQ_IDLE;
		porState.pwrtCnt = POWERUP_DELAY_TIMER_LOAD;
		porState.status = `DEWG_POR_IRQ;
		porState.enable = `DEWG_POR_IRQ;
	end

	// other resets: keep data, address and delay state, flag a cut store
	always_comb
	begin
		rstState = porState;
		rstState.data = s.data;
		rstState.addr = s.addr;
		// only power-on reloads the delay timer
		rstState.pwrtCnt = s.pwrtCnt;
		rstState.abortFlag = s.abortFlag | s.store;
		rstState.status = s.status;
		rstState.status[`DEWG_IRQ_ABORT] =
			s.status[`DEWG_IRQ_ABORT] | s.store;
		// firmware must re-arm interrupts after any reset
		rstState.enable = `DEWG_POR_IRQ;
		rstState.permit = 1'b0;
	end

	// state register; power-on outranks the other resets
	// both resets load whole images built above, never partial fields
	always_ff @(posedge clk_sys)
	begin
		if (powerOnRst)
			s <= porState;
		else if (sys_rst)
			s <= rstState;
		else
			s <= next_s;
	end

	// array write only at the end of a finished store, never on reset
	always_ff @(posedge clk_sys)
	begin
		if (memWe && !powerOnRst && !sys_rst)
			mem[memIdx] <= s.data;
	end

	// outputs come straight from the state register
	assign regRdData = s.rdData;
	assign irq       = s.irq;

endmodule : dewg_data_eeprom_write_guard

`default_nettype wire

/* rtl/dewg_params.svh */
// constants of the data eeprom write guard: offsets, fields, resets, timing
// assumes inclusion by bare name from the package and the top module
`ifndef DEWG_PARAMS_SVH
`define DEWG_PARAMS_SVH

// register offsets on the register port
`define DEWG_OFS_DATA     8'h9a
`define DEWG_OFS_ADDRESS  8'h9b
`define DEWG_OFS_CONTROL  8'h9c
`define DEWG_OFS_UNLOCK   8'h9d
`define DEWG_OFS_STATUS   8'ha0
`define DEWG_OFS_CLEAR    8'ha1
`define DEWG_OFS_ENABLE   8'ha2

// eeprom_control field positions
`define DEWG_BIT_FETCH    0
`define DEWG_BIT_STORE    1
`define DEWG_BIT_PERMIT   2
`define DEWG_BIT_ABORT    3

// interrupt status layout
`define DEWG_IRQ_DONE     0
`define DEWG_IRQ_ABORT    1
`define DEWG_IRQ_W        2

// reset values
`define DEWG_POR_BYTE     8'h00
`define DEWG_POR_IRQ      2'h0

// unlock keys and spacing in cycles between unlock steps
`define DEWG_KEY_FIRST    8'h55
`define DEWG_KEY_SECOND   8'haa
`define DEWG_SEQ_GAP      2
`define DEWG_SEQ_W        4

// timing
`define DEWG_CLK_KHZ      10000
`define DEWG_POWERUP_DELAY_TIMER_MS      72
`define DEWG_POWERUP_DELAY_TIMER_CYCLES  (`DEWG_POWERUP_DELAY_TIMER_MS * `DEWG_CLK_KHZ)
`define DEWG_POWERUP_DELAY_TIMER_W       20
`define DEWG_STORE_CYCLES 40
`define DEWG_STORE_W      16
`define DEWG_DEPTH        128

`endif

/* rtl/dewg_pkg.sv */
// types shared by the data eeprom write guard
// assumes dewg_params.svh is on the include path
`default_nettype none
`include "dewg_params.svh"

package dewg_pkg;

	// progress of the unlock sequence
	typedef enum logic [1:0]
	{
		SEQ_IDLE,
		SEQ_GOT_FIRST,
		SEQ_ARMED
	} dewg_seq_e;

	// whole state of the block
	typedef struct packed
	{
		logic [7:0]                 data;
		logic [7:0]                 addr;
		logic                       abortFlag;
		logic                       permit;
		logic                       store;
		logic                       fetch;
		dewg_seq_e                  seq;
		logic [`DEWG_SEQ_W-1:0]     seqCnt;
		logic [`DEWG_POWERUP_DELAY_TIMER_W-1:0]    pwrtCnt;
		logic [`DEWG_STORE_W-1:0]   storeCnt;
		logic [`DEWG_IRQ_W-1:0]     status;
		logic [`DEWG_IRQ_W-1:0]     enable;
		logic [7:0]                 rdData;
		logic                       irq;
	} dewg_state_s;

endpackage : dewg_pkg

`default_nettype wire

/* verification/dewg_cpu_model.sv */
// partner: cpu core side of the register port, one access per cycle
// assumes callers enter its tasks right after a rising edge
`default_nettype none
module dewg_cpu_model
(
	input  wire logic      clk_sys,
	output var logic [7:0] regAddr,
	output var logic [7:0] regWrData,
	output var logic       regWrEn,
	output var logic       regRdEn
);
	timeunit 1ns;
	timeprecision 1ns;
	// quiet bus at time zero
	initial
	begin
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
	end
	// strobes stay up so back-to-back accesses never assign twice
	task automatic acc(input logic wr, input logic [7:0] a, d);
		regWrEn <= wr;
		regRdEn <= !wr;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk_sys);
	endtask : acc
	// idle lines toggle so a stale value never looks valid
	task automatic idle(input int n);
		repeat (n)
		begin
			regWrEn <= 1'b0;
			regRdEn <= 1'b0;
			regAddr <= ~regAddr;
			regWrData <= ~regWrData;
			@(posedge clk_sys);
		end
	endtask : idle
endmodule : dewg_cpu_model
`default_nettype wire

/* verification/dewg_guard_assertions.sv */
// checker: register port and interrupt relations of the write guard
// assumes a bind to the top module and one clock domain
`default_nettype none
module dewg_guard_assertions
(
	input wire logic       clk_sys,
	input wire logic       sys_rst,
	input wire logic       powerOnRst,
	input wire logic       codeProtect,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic       regWrEn,
	input wire logic       regRdEn,
	input wire logic [7:0] regRdData,
	input wire logic       irq
);
	timeunit 1ns;
	timeprecision 1ns;
	// decoded strobes keep the properties short
	wire logic anyRst = sys_rst || powerOnRst;
	wire logic rdCtl = regRdEn && regAddr == 8'h9c;
	default clocking cb @(posedge clk_sys);
	endclocking
	rd_idle_a: assert property (disable iff (anyRst)
		!$past(regRdEn) |-> regRdData == 8'h00) else $error("stray data");
	unlock_rd_a: assert property (disable iff (anyRst)
		regRdEn && regAddr == 8'h9d |=> regRdData == 8'h00)
		else $error("unlock port read not zero");
	ctrl_upper_a: assert property (disable iff (anyRst)
		rdCtl |=> regRdData[7:4] == 4'h0) else $error("upper bits set");
	ctrl_por_a: assert property (disable iff (sys_rst)
		powerOnRst ##1 rdCtl |=> regRdData == 8'h00)
		else $error("control not clear after power-on");
	data_rw_a: assert property (disable iff (anyRst)
		regWrEn && regAddr == 8'h9a ##1 regRdEn && regAddr == 8'h9a
		|=> regRdData == $past(regWrData, 2)) else $error("data lost");
	addr_rw_a: assert property (disable iff (anyRst)
		regWrEn && regAddr == 8'h9b ##1 regRdEn && regAddr == 8'h9b
		|=> regRdData == $past(regWrData, 2)) else $error("address lost");
	fetch_clr_a: assert property (disable iff (anyRst)
		regWrEn && regAddr == 8'h9c && regWrData[0] ##2 rdCtl
		|=> !regRdData[0]) else $error("fetch bit stuck");
	rst_irq_a: assert property (disable iff (powerOnRst)
		sys_rst |=> !irq) else $error("irq after reset");
endmodule : dewg_guard_assertions
bind dewg_data_eeprom_write_guard dewg_guard_assertions u_chk
(
	.clk_sys(clk_sys), .sys_rst(sys_rst), .powerOnRst(powerOnRst),
	.codeProtect(codeProtect), .regAddr(regAddr), .regWrData(regWrData),
	.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .irq(irq)
);
`default_nettype wire

/* verification/tb_top.sv */
// bench: cpu model drives the guard, read data checked from a queue
// assumes short power-up and store counts set below
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int POWERUP_DELAY_TIMER = 20;
	localparam int STC = 8;
	logic clk_sys = 1'b0, sys_rst = 1'b1, powerOnRst = 1'b1, codeProtect = 1'b0;
	wire logic [7:0] regAddr, regWrData, regRdData;
	wire logic regWrEn, regRdEn, irq;
	logic [7:0] expQ[$];
	logic rdPend = 1'b0;
	logic [31:0] seed = 32'h0000b648;
	logic [7:0] a, d;
	int bad_count = 0, check_count = 0;
	// 10 MHz clock
	always #50 clk_sys = ~clk_sys;
	dewg_cpu_model u_cpu (.clk_sys(clk_sys), .regAddr(regAddr),
		.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn));
	dewg_data_eeprom_write_guard #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER), .STORE_CYCLES(STC))
	u_dewg_data_eeprom_write_guard (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.powerOnRst(powerOnRst), .codeProtect(codeProtect), .regAddr(regAddr),
		.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regRdData(regRdData), .irq(irq));
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd
	task automatic chk(input string n, input logic [7:0] s, e);
		check_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic rd(input logic [7:0] ad, e);
		expQ.push_back(e);
		u_cpu.acc(1'b0, ad, 8'h00);
	endtask : rd
	task automatic wr(input logic [7:0] ad, dt);
		u_cpu.acc(1'b1, ad, dt);
	endtask : wr
	// unlock keys then control write, gap cycles apart
	task automatic seq(input logic [7:0] k2, input int gap, input logic [7:0] c);
		wr(8'h9d, 8'h55);
		u_cpu.idle(gap - 1);
		wr(8'h9d, k2);
		u_cpu.idle(gap - 1);
		wr(8'h9c, c);
	endtask : seq
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	// read data stands only in the cycle after the strobe
	always @(posedge clk_sys)
	begin
		rdPend <= regRdEn;
		if (rdPend)
			chk("read data", regRdData, expQ.pop_front());
	end
	// watchdog at 3000 cycles, well beyond the roughly 110 cycles of the tests
	initial
	begin
		#(3000 * 100);
		bad_count++;
		test_done();
	end
	initial
	begin
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		powerOnRst <= 1'b0;
		rd(8'h9c, 8'h00);
		rd(8'h9d, 8'h00);
		rd(8'h50, 8'h00);
		wr(8'h9c, 8'h04);
		seq(8'haa, 2, 8'h06);
		rd(8'h9c, 8'h04);
		$display("test power-up done");
		u_cpu.idle(POWERUP_DELAY_TIMER);
		a = rnd();
		d = rnd();
		codeProtect <= ~d[0];
		wr(8'h9b, a);
		rd(8'h9b, a);
		wr(8'h9a, d);
		rd(8'h9a, d);
		wr(8'ha2, 8'h01);
		wr(8'h9c, 8'hf4);
		rd(8'h9c, 8'h04);
		seq(8'haa, 2, 8'h06);
		rd(8'h9c, 8'h06);
		wr(8'h9c, 8'h04);
		rd(8'h9c, 8'h06);
		u_cpu.idle(STC - 4);
		rd(8'h9c, 8'h06);
		rd(8'h9c, 8'h04);
		rd(8'ha0, 8'h01);
		chk("irq", {7'h00, irq}, 8'h01);
		wr(8'h9a, 8'h00);
		wr(8'h9c, 8'h05);
		u_cpu.idle(1);
		rd(8'h9c, 8'h04);
		rd(8'h9a, d);
		wr(8'ha1, 8'h01);
		u_cpu.idle(2);
		chk("irq", {7'h00, irq}, 8'h00);
		$display("test store done");
		// wrong key, spacing too long or short, permit latch off
		seq(8'hab, 2, 8'h06);
		rd(8'h9c, 8'h04);
		seq(8'haa, 3, 8'h06);
		rd(8'h9c, 8'h04);
		seq(8'haa, 1, 8'h06);
		rd(8'h9c, 8'h04);
		wr(8'h9c, 8'h00);
		seq(8'haa, 2, 8'h02);
		rd(8'h9c, 8'h00);
		rd(8'ha0, 8'h00);
		$display("test refusals done");
		// a second reset cuts a running store
		codeProtect <= d[0];
		wr(8'h9c, 8'h04);
		seq(8'haa, 2, 8'h06);
		u_cpu.idle(2);
		sys_rst <= 1'b1;
		u_cpu.idle(1);
		sys_rst <= 1'b0;
		rd(8'h9c, 8'h08);
		rd(8'h9a, d);
		rd(8'h9b, a);
		rd(8'ha0, 8'h02);
		powerOnRst <= 1'b1;
		u_cpu.idle(2);
		powerOnRst <= 1'b0;
		rd(8'h9c, 8'h00);
		rd(8'h9a, 8'h00);
		u_cpu.idle(2);
		$display("test resets done");
		test_done();
	end
endmodule : tb_top
`default_nettype wire
